// >>> pcs_card_slave.sv
// Card-bus slave front end: space decode, config registers, memory steering
`timescale 1ns/1ns
module pcs_card_slave (
    input  wire logic                          i_core_clk,
    input  wire logic                          i_rstn,
    input  wire logic                          i_ce,
    input  wire logic                          i_card_mode_strap,
    input  wire logic                          i_shared_memory_match,
    input  wire logic                          i_shared_mem_mode,
    input  wire logic                          i_prom_write_enable,
    input  wire logic                          i_sleep_n,
    input  wire logic                          i_byte_high_enable_ce2_n,
    input  wire logic                          i_boot_prom_match_ce1_n,
    input  wire logic                          i_aen_reg_n,
    input  wire logic                          i_memw_we_n,
    input  wire logic                          i_memr_oe_n,
    input  wire logic                          i_iord_n,
    input  wire logic                          i_iowr_n,
    input  wire logic [pcs_pkg::ADDR_W-1:0]    i_addr,
    input  wire logic [pcs_pkg::DATA_W-1:0]    i_data,
    input  wire logic [7:0]                    i_flash_rdata,
    output logic      [pcs_pkg::DATA_W-1:0]    o_data,
    output logic                               o_data_oe_n,
    output logic                               o_io_channel_ready_wait,
    output logic                               o_flash_chip_select_n,
    output logic                               o_sram_chip_select_n,
    output logic                               o_mem_oe_n,
    output logic                               o_mem_we_n,
    output logic      [pcs_pkg::ADDR_W-1:0]    o_mem_addr,
    output logic                               o_io_rd,
    output logic                               o_io_wr,
    output logic      [pcs_pkg::IO_SEL_W-1:0]  o_io_sel,
    output logic      [7:0]                    o_cfg_index,
    output logic                               o_io_enabled,
    output logic                               o_card_mode
);
    localparam int NPIN = 7;

    pcs_pkg::pcs_strobe_s strobe_raw;
    pcs_pkg::pcs_strobe_s strobe;
    logic [NPIN-1:0]      strobe_sync;
    logic [pcs_pkg::ADDR_W-1:0] addr_q;
    logic [pcs_pkg::DATA_W-1:0] wdata_q;
    logic                 match_q;
    logic                 mode_q;
    logic                 mode_q2;

    // Pins from the card socket pass the filtered synchroniser
    assign strobe_raw = '{ce1_n:  i_boot_prom_match_ce1_n,
                          ce2_n:  i_byte_high_enable_ce2_n,
                          reg_n:  i_aen_reg_n,
                          oe_n:   i_memr_oe_n,
                          we_n:   i_memw_we_n,
                          iord_n: i_iord_n,
                          iowr_n: i_iowr_n};

    pcs_sync #(
        .W    (NPIN),
        .INIT ('1)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_ce       (i_ce),
        .i_async    (strobe_raw),
        .o_sync     (strobe_sync)
    );
    assign strobe = strobe_sync;

    // Address, data, the memory match and the mode strap are sampled alongside the strobes;
    // they are stable while the strobes settle, so one register suffices; the mode strap gets two
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            addr_q  <= 16'h0000;
            wdata_q <= 16'h0000;
            match_q <= 1'b1;
            mode_q  <= 1'b0;
            mode_q2 <= 1'b0;
        end else if (i_ce) begin
            addr_q  <= i_addr;
            wdata_q <= i_data;
            match_q <= i_shared_memory_match;
            mode_q  <= i_card_mode_strap;
            mode_q2 <= mode_q;
        end
    end

    // Cycle decode
    logic card_sel;
    logic attr_acc;
    logic comm_acc;
    logic mem_rd;
    logic mem_wr;
    logic io_rd;
    logic io_wr;
    logic attr_even;
    logic cfg_hit;
    logic [1:0] cfg_idx;
    logic [7:0] cfg [pcs_pkg::NUM_CCR];
    logic io_en;

    always_comb begin
        card_sel  = mode_q2 && (!strobe.ce1_n || !strobe.ce2_n);
        mem_rd    = card_sel && !strobe.oe_n;
        mem_wr    = card_sel && !strobe.we_n;
        attr_acc  = !strobe.reg_n && (mem_rd || mem_wr);
        comm_acc  = strobe.reg_n && (mem_rd || mem_wr);
        // I/O ignored until configured: memory-only card meanwhile
        io_rd     = card_sel && io_en && !strobe.iord_n;
        io_wr     = card_sel && io_en && !strobe.iowr_n;
        attr_even = !addr_q[0];
        cfg_hit   = attr_acc && attr_even &&
                    (addr_q[9:0] >= pcs_pkg::ADDR_OPTION_CFG) &&
                    (addr_q[9:0] <= pcs_pkg::ADDR_CFG_D) &&
                    (addr_q[15:10] == 6'h00);
        cfg_idx   = addr_q[2:1];
    end

    assign io_en = cfg[0][pcs_pkg::IO_EN_BIT];

    // Configuration register bank
    logic [7:0] next_cfg [pcs_pkg::NUM_CCR];
    logic       wr_seen;
    logic       next_wr_seen;

    // A write lands once per WE low phase; odd addresses never write
    always_comb begin
        for (int k = 0; k < pcs_pkg::NUM_CCR; k++) begin
            next_cfg[k] = cfg[k];
        end
        next_wr_seen = mem_wr;
        if (cfg_hit && mem_wr && !wr_seen) begin
            next_cfg[cfg_idx] = wdata_q[7:0];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            cfg[0]  <= pcs_pkg::RST_OPTION_CFG;
            cfg[1]  <= pcs_pkg::RST_CFG_OTHER;
            cfg[2]  <= pcs_pkg::RST_CFG_OTHER;
            cfg[3]  <= pcs_pkg::RST_CFG_OTHER;
            wr_seen <= 1'b0;
        end else if (i_ce) begin
            for (int k = 0; k < pcs_pkg::NUM_CCR; k++) begin
                cfg[k] <= next_cfg[k];
            end
            wr_seen <= next_wr_seen;
        end
    end

    // Cycle state: idle, active strobe, waiting for strobes to drop
    pcs_pkg::pcs_state_e state;
    pcs_pkg::pcs_state_e next_state;
    logic active;

    assign active = mem_rd || mem_wr || io_rd || io_wr;

    always_comb begin
        next_state = state;
        case (state)
            pcs_pkg::PCS_ST_IDLE: begin
                if (active) begin
                    next_state = pcs_pkg::PCS_ST_ACT;
                end
            end
            pcs_pkg::PCS_ST_ACT: begin
                next_state = pcs_pkg::PCS_ST_DONE;
            end
            pcs_pkg::PCS_ST_DONE: begin
                if (!active) begin
                    next_state = pcs_pkg::PCS_ST_IDLE;
                end
            end
            default: begin
                next_state = pcs_pkg::PCS_ST_IDLE;
            end
        endcase
    end

    // Output side: memory steering, read data, I/O strobes
    logic [pcs_pkg::DATA_W-1:0]   next_data;
    logic                         next_data_oe_n;
    logic                         next_wait;
    logic                         next_flash_n;
    logic                         next_sram_n;
    logic                         next_moe_n;
    logic                         next_mwe_n;
    logic [pcs_pkg::ADDR_W-1:0]   next_maddr;
    logic                         next_io_rd;
    logic                         next_io_wr;
    logic [pcs_pkg::IO_SEL_W-1:0] next_io_sel;
    logic                         flash_pick;
    logic                         sram_pick;

    always_comb begin
        // Flash for attribute (non-register) space and matched common space
        flash_pick = (attr_acc && !cfg_hit) ||
                     (comm_acc && match_q);
        sram_pick  = comm_acc && !match_q && i_shared_mem_mode;
        next_flash_n = !flash_pick;
        next_sram_n  = !sram_pick;
        next_moe_n   = !(mem_rd && (flash_pick || sram_pick));
        // Flash writes gated by the programming enable; SRAM always
        next_mwe_n   = !(mem_wr && ((flash_pick && i_prom_write_enable) ||
                                    sram_pick));
        // Attribute origin is flash byte 0; each even byte is one flash byte
        next_maddr   = attr_acc ? {1'b0, addr_q[15:1]} : addr_q;
        next_io_rd   = io_rd;
        next_io_wr   = io_wr && (state == pcs_pkg::PCS_ST_IDLE);
        next_io_sel  = addr_q[pcs_pkg::IO_SEL_W-1:0];
        next_data      = 16'h0000;
        next_data_oe_n = 1'b1;
        if (mem_rd && cfg_hit) begin
            next_data      = {8'h00, cfg[cfg_idx]};
            next_data_oe_n = 1'b0;
        end else if (mem_rd && flash_pick) begin
            next_data      = {8'h00, i_flash_rdata};
            next_data_oe_n = 1'b0;
        end
        // Hold the host off for the first cycle of each access
        next_wait = !(active && state == pcs_pkg::PCS_ST_IDLE);
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            state                   <= pcs_pkg::PCS_ST_IDLE;
            o_data                  <= 16'h0000;
            o_data_oe_n             <= 1'b1;
            o_io_channel_ready_wait <= 1'b1;
            o_flash_chip_select_n   <= 1'b1;
            o_sram_chip_select_n    <= 1'b1;
            o_mem_oe_n              <= 1'b1;
            o_mem_we_n              <= 1'b1;
            o_mem_addr              <= 16'h0000;
            o_io_rd                 <= 1'b0;
            o_io_wr                 <= 1'b0;
            o_io_sel                <= 5'h00;
            o_cfg_index             <= 8'h00;
            o_io_enabled            <= 1'b0;
            o_card_mode             <= 1'b0;
        end else if (i_ce) begin
            state                   <= next_state;
            o_data                  <= next_data;
            o_data_oe_n             <= next_data_oe_n;
            o_io_channel_ready_wait <= next_wait;
            o_flash_chip_select_n   <= next_flash_n;
            o_sram_chip_select_n    <= next_sram_n;
            o_mem_oe_n              <= next_moe_n;
            o_mem_we_n              <= next_mwe_n;
            o_mem_addr              <= next_maddr;
            o_io_rd                 <= next_io_rd;
            o_io_wr                 <= next_io_wr;
            o_io_sel                <= next_io_sel;
            o_cfg_index             <= next_cfg[0];
            o_io_enabled            <= next_cfg[0][pcs_pkg::IO_EN_BIT];
            o_card_mode             <= mode_q2;
        end
    end

    // Checks
    property p_io_gate;
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_io_rd |-> $past(io_en);
    endproperty
    a_io_gate: assert property (p_io_gate)
        else $error("I/O read passed while I/O disabled");

    property p_flash_write;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (!o_mem_we_n && !o_flash_chip_select_n) |->
            $past(i_prom_write_enable);
    endproperty
    a_flash_write: assert property (p_flash_write)
        else $error("Flash write without programming enable");

    property p_sram_sel;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !o_sram_chip_select_n |-> $past(strobe.reg_n && !match_q);
    endproperty
    a_sram_sel: assert property (p_sram_sel)
        else $error("SRAM selected outside unmatched common space");

    property p_mode;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (!i_card_mode_strap && i_ce) [*4] |-> !o_card_mode;
    endproperty
    a_mode: assert property (p_mode)
        else $error("Card mode while strap low");

    property p_odd_attr;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && attr_acc && addr_q[0]) |=> (cfg[0] == $past(cfg[0]));
    endproperty
    a_odd_attr: assert property (p_odd_attr)
        else $error("Odd attribute write changed a config register");

    property p_sel;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && io_rd) |=> (o_io_sel == $past(addr_q[4:0]));
    endproperty
    a_sel: assert property (p_sel)
        else $error("I/O select not from low five address bits");

    property p_attr_flash;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && attr_acc && !cfg_hit) |=> !o_flash_chip_select_n;
    endproperty
    a_attr_flash: assert property (p_attr_flash)
        else $error("Attribute access did not select flash");

    property p_cfg_wr;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && cfg_hit && mem_wr && !wr_seen && cfg_idx == 2'h1) |=>
            (cfg[1] == $past(wdata_q[7:0]));
    endproperty
    a_cfg_wr: assert property (p_cfg_wr)
        else $error("Config register write lost");
endmodule

// >>> pcs_pkg.sv
// Package for the card-bus slave front end: offsets, fields, types
package pcs_pkg;

    // Attribute-memory byte addresses of the four configuration registers
    localparam logic [9:0] ADDR_OPTION_CFG = 10'h3F0;
    localparam logic [9:0] ADDR_CFG_B      = 10'h3F2;
    localparam logic [9:0] ADDR_CFG_C      = 10'h3F4;
    localparam logic [9:0] ADDR_CFG_D      = 10'h3F6;

    // Reset values of the configuration registers
    localparam logic [7:0] RST_OPTION_CFG = 8'h00;
    localparam logic [7:0] RST_CFG_OTHER  = 8'h00;

    // Field layout of the option register
    localparam int IDX_LSB    = 0;
    localparam int IDX_MSB    = 5;
    localparam int IO_EN_BIT  = 0;

    // Card bus widths
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 16;
    localparam int IO_SEL_W   = 5;
    localparam int NUM_CCR    = 4;

    // Cycle state tracked from the strobes: idle, active, done
    typedef enum logic [1:0] {
        PCS_ST_IDLE = 2'b00,
        PCS_ST_ACT  = 2'b01,
        PCS_ST_DONE = 2'b11
    } pcs_state_e;

    // Card bus inputs taken from the pins
    typedef struct packed {
        logic              ce1_n;
        logic              ce2_n;
        logic              reg_n;
        logic              oe_n;
        logic              we_n;
        logic              iord_n;
        logic              iowr_n;
    } pcs_strobe_s;

    // Memory-side selects presented toward flash and packet SRAM
    typedef struct packed {
        logic              flash_cs_n;
        logic              sram_cs_n;
        logic              mem_oe_n;
        logic              mem_we_n;
    } pcs_memsel_s;

endpackage

// >>> pcs_sync.sv
// Three-stage pin synchroniser with second/third agreement filter
`timescale 1ns/1ns
module pcs_sync #(
    parameter int                W   = 7,
    parameter logic [W-1:0]      INIT = '1
) (
    input  wire logic            i_core_clk,
    input  wire logic            i_rstn,
    input  wire logic            i_ce,
    input  wire logic [W-1:0]    i_async,
    output logic      [W-1:0]    o_sync
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] held;
    logic [W-1:0] next_held;

    // A bit only changes once stages two and three agree
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            always_comb begin
                next_held[g] = (s2[g] == s3[g]) ? s3[g] : held[g];
            end
        end
    endgenerate

    // Register stages; the first stage feeds only the second
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            s1   <= INIT;
            s2   <= INIT;
            s3   <= INIT;
            held <= INIT;
        end else if (i_ce) begin
            s1   <= i_async;
            s2   <= s1;
            s3   <= s2;
            held <= next_held;
        end
    end

    assign o_sync = held;
endmodule

// >>> pcs_host_model.sv
// Behavioural card-bus host socket that runs memory and I/O cycles
`timescale 1ns/1ns
module pcs_host_model #(
    parameter logic [15:0] IO_BASE = 16'h0300
) (
    input  wire logic                       i_core_clk,
    input  wire logic                       i_wait_n,
    input  wire logic [pcs_pkg::DATA_W-1:0] i_rdata,
    output pcs_pkg::pcs_strobe_s            o_strb,
    output logic      [pcs_pkg::ADDR_W-1:0] o_addr,
    output logic      [pcs_pkg::DATA_W-1:0] o_wdata
);
    // Idle bus: strobes high, released lines at their pull-down level
    initial begin
        o_strb  = '1;
        o_addr  = '0;
        o_wdata = '0;
    end

    // Kind: bits 2:1 space (0 attribute, 1 common, 2 I/O), bit 0 write
    task automatic start(input logic [2:0] kind, input logic [15:0] addr,
                         input logic [15:0] wdata);
        logic io;
        logic wr;
        io = kind[2];
        wr = kind[0];
        @(negedge i_core_clk);
        o_addr  = addr;                    // Address settles before strobes
        o_wdata = wr ? wdata : '0;
        @(negedge i_core_clk);
        // Upper I/O bits are our job; mismatch means the card is not chosen
        o_strb.ce1_n  = io && (addr[15:6] != IO_BASE[15:6]);
        o_strb.reg_n  = (kind[2:1] == 2'b01);
        o_strb.oe_n   = io || wr;
        o_strb.we_n   = io || !wr;
        o_strb.iord_n = !io || wr;
        o_strb.iowr_n = !io || !wr;
    endtask

    // Hold until the card reports ready, take read data, then release
    task automatic finish(output logic [15:0] rdata);
        int n;
        n = 0;
        @(posedge i_core_clk);
        while (i_wait_n !== 1'b1 && n < 64) begin
            @(posedge i_core_clk);
            n++;
        end
        rdata = i_rdata;
        @(negedge i_core_clk);
        o_strb  = '1;
        // Address and data outlive the strobes: the card sees the strobes
        // drop only after its filter, so the bus must stay put until then
        repeat (5) @(negedge i_core_clk);
        o_addr  = '0;
        o_wdata = '0;
    endtask
endmodule

// >>> pcs_card_slave_tb.sv
// Self-checking bench for the card-bus slave front end
`timescale 1ns/1ns
module pcs_card_slave_tb;
    localparam logic [2:0] AR = 3'h0, AW = 3'h1, CR = 3'h2, CW = 3'h3;
    localparam logic [2:0] IR = 3'h4, IW = 3'h5;
    localparam logic [5:0] IDLE = 6'h3D;

    logic                 clk = 1'b0;
    logic                 rstn = 1'b0;
    logic                 strap = 1'b1;
    logic                 smm = 1'b1;
    logic                 smode = 1'b0;
    logic                 pwe = 1'b0;
    pcs_pkg::pcs_strobe_s strb;
    logic [15:0]          addr, wdata, o_data, o_mem_addr, rd;
    logic [7:0]           flash_rdata, o_cfg_index;
    logic [4:0]           o_io_sel, s_sel;
    logic [5:0]           snap;
    logic [15:0]          s_maddr;
    logic                 o_data_oe_n, o_wait, o_fcs_n, o_scs_n, o_oe_n;
    logic                 o_we_n, o_io_rd, o_io_wr, o_io_en, o_card_mode;
    int                   mismatches = 0, cmp_count = 0, pulses = 0, cyc;
    int                   waits = 0;
    logic [7:0]           vals [4] = '{8'h41, 8'h5C, 8'hC3, 8'h3A};

    always #20 clk = ~clk;

    // Flash byte is a fixed function of the flash address it is given
    assign flash_rdata = o_mem_addr[7:0] ^ 8'h5A;

    pcs_card_slave DUT (
        .i_core_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
        .i_card_mode_strap(strap), .i_shared_memory_match(smm),
        .i_shared_mem_mode(smode), .i_prom_write_enable(pwe),
        .i_sleep_n(1'b1),
        .i_byte_high_enable_ce2_n(strb.ce2_n),
        .i_boot_prom_match_ce1_n(strb.ce1_n), .i_aen_reg_n(strb.reg_n),
        .i_memw_we_n(strb.we_n), .i_memr_oe_n(strb.oe_n),
        .i_iord_n(strb.iord_n), .i_iowr_n(strb.iowr_n),
        .i_addr(addr), .i_data(wdata), .i_flash_rdata(flash_rdata),
        .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .o_io_channel_ready_wait(o_wait), .o_flash_chip_select_n(o_fcs_n),
        .o_sram_chip_select_n(o_scs_n), .o_mem_oe_n(o_oe_n),
        .o_mem_we_n(o_we_n), .o_mem_addr(o_mem_addr), .o_io_rd(o_io_rd),
        .o_io_wr(o_io_wr), .o_io_sel(o_io_sel), .o_cfg_index(o_cfg_index),
        .o_io_enabled(o_io_en), .o_card_mode(o_card_mode)
    );

    pcs_host_model HST (
        .i_core_clk(clk), .i_wait_n(o_wait), .i_rdata(o_data),
        .o_strb(strb), .o_addr(addr), .o_wdata(wdata)
    );

    // Count write pulses and cut a hung run short
    always @(posedge clk) begin
        if (o_io_wr === 1'b1) pulses++;
        if (o_wait === 1'b0) waits++;
        cyc++;
        if (cyc > 20000) begin
            mismatches++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One host cycle; memory-side outputs captured mid-cycle
    task automatic access(input logic [2:0] k, input logic [15:0] a,
                          input logic [15:0] d);
        HST.start(k, a, d);
        repeat (6) @(negedge clk);
        snap = {o_fcs_n, o_scs_n, o_oe_n, o_we_n, o_io_rd, o_data_oe_n};
        s_maddr = o_mem_addr;
        s_sel = o_io_sel;
        HST.finish(rd);
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        int p;
        int w;
        cyc = 0;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        chk("card_mode", 16'h1, 16'(o_card_mode));
        chk("cfg_index", 16'h0, 16'(o_cfg_index));
        snap = {o_fcs_n, o_scs_n, o_oe_n, o_we_n, o_io_rd, o_data_oe_n};
        chk("idle", 16'(IDLE), 16'(snap));
        // Unconfigured card must ignore I/O strobes
        p = pulses;
        access(IR, 16'h0337, 16'h0);
        chk("io_rd off", 16'h0, 16'(snap[1]));
        access(IW, 16'h0337, 16'h1234);
        chk("io_wr off", 16'(p), 16'(pulses));
        for (int i = 0; i < 4; i++) begin
            access(AR, 16'h03F0 + 16'(2 * i), 16'h0);
            chk("cfg reset", 16'h0, 16'(rd[7:0]));
        end
        for (int i = 3; i >= 0; i--)
            access(AW, 16'h03F0 + 16'(2 * i), 16'(vals[i]));
        // Odd attribute writes must leave the registers alone
        access(AW, 16'h03F1, 16'h00FF);
        access(AW, 16'h03F3, 16'h00FF);
        for (int i = 0; i < 4; i++) begin
            access(AR, 16'h03F0 + 16'(2 * i), 16'h0);
            chk("cfg read", 16'(vals[i]), 16'(rd[7:0]));
        end
        chk("cfg_index", 16'h41, 16'(o_cfg_index));
        chk("io_en", 16'h1, 16'(o_io_en));
        // Bit 5 set in the address must not reach the select
        p = pulses;
        w = waits;
        access(IW, 16'h0337, 16'h1234);
        chk("io_wr pulse", 16'(p + 1), 16'(pulses));
        chk("wait cycles", 16'(w + 1), 16'(waits));
        chk("io_sel", 16'h17, 16'(s_sel));
        access(IR, 16'h0337, 16'h0);
        chk("io_rd on", 16'h1, 16'(snap[1]));
        access(IW, 16'h0737, 16'h1234);
        chk("io other win", 16'(p + 1), 16'(pulses));
        // Attribute reads fetch packed even bytes from flash
        access(AR, 16'h0010, 16'h0);
        chk("attr sel", 16'h14, 16'(snap));
        chk("attr addr", 16'h0008, s_maddr);
        chk("attr data", 16'h0052, rd);
        access(AR, 16'h0000, 16'h0);
        chk("attr origin", 16'h0000, s_maddr);
        chk("origin data", 16'h005A, rd);
        access(CR, 16'h0010, 16'h0);
        chk("com flash", 16'h14, 16'(snap));
        chk("com addr", 16'h0010, s_maddr);
        smm = 1'b0;
        smode = 1'b1;
        access(CR, 16'h0010, 16'h0);
        chk("com sram", 16'h25, 16'(snap));
        smm = 1'b1;
        // Flash writes gated by the programming enable
        access(CW, 16'h0020, 16'h00A5);
        chk("we blocked", 16'h1, 16'(snap[2]));
        pwe = 1'b1;
        access(CW, 16'h0020, 16'h00A5);
        chk("we pass", 16'h0, 16'({snap[5], snap[2]}));
        strap = 1'b0;
        repeat (6) @(negedge clk);
        chk("isa mode", 16'h0, 16'(o_card_mode));
        strap = 1'b1;
        repeat (6) @(negedge clk);
        chk("card mode", 16'h1, 16'(o_card_mode));
        test_done();
    end
endmodule
